// file: hdl/ctu_edge_ctrl.sv
// module: apb-controlled edge channels, event flags and current-source gate of the charge-time unit
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps

module ctu_edge_ctrl (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// edge trigger sources
	input wire ctu_pkg::ctu_src_t src_in,
	// analog side
	output ctu_pkg::ctu_ana_t ana_out,
	// interrupt
	output logic irq
);

	ctu_pkg::ctu_state_t s_q; // registered state
	ctu_pkg::ctu_state_t s_d; // next state

	logic [1:0] sel1; // channel 1 source select
	logic [1:0] sel2; // channel 2 source select
	logic lvl1; // selected raw level, channel 1
	logic lvl2; // selected raw level, channel 2
	logic ev1; // channel 1 at event level
	logic ev2; // channel 2 at event level
	logic gate_on; // edges allowed through
	logic wr_acc; // write taken this edge
	logic rd_acc; // read taken this edge
	logic [7:0] wb; // low byte of write data
	logic [1:0] flags_nx; // next value of both status flags
	logic cur_nx; // next current source state

	assign sel1 = s_q.edge_low[ctu_pkg::SEL1_LSB +: 2];
	assign sel2 = s_q.edge_low[ctu_pkg::SEL2_LSB +: 2];

	// source multiplexer per channel
	function automatic logic pick(input logic [1:0] sel, input logic [3:0] lv);
		logic r;
		r = 1'b0;
		case (sel)
			ctu_pkg::SRC_PIN_A: r = lv[3];
			ctu_pkg::SRC_PIN_B: r = lv[2];
			ctu_pkg::SRC_TIMER: r = lv[1];
			ctu_pkg::SRC_CMP: r = lv[0];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// level compare, using synchronised pins and raw timer and cmp levels so config writes see live levels
	always_comb begin
		lvl1 = pick(sel1, {s_q.sync2[1], s_q.sync2[0], src_in.timer, src_in.cmp});
		lvl2 = pick(sel2, {s_q.sync2[1], s_q.sync2[0], src_in.timer, src_in.cmp});
		// polarity low means an active-low level counts as the event
		ev1 = s_q.edge_low[ctu_pkg::POL1_BIT] ? lvl1 : ~lvl1;
		ev2 = s_q.edge_low[ctu_pkg::POL2_BIT] ? lvl2 : ~lvl2;
		gate_on = s_q.ctrl_high[ctu_pkg::UNITEN_BIT] & s_q.ctrl_high[ctu_pkg::EDGE_INPUTS_ENABLE_BIT];
	end

	assign wr_acc = psel & penable & pwrite & s_q.pready;
	assign rd_acc = psel & penable & ~pwrite & s_q.pready;
	assign wb = pwdata[7:0];

	// next-state logic
	always_comb begin
		s_d = s_q;
		// pin synchronisers, stage one feeds stage two only
		s_d.sync1 = {src_in.pin_a, src_in.pin_b};
		s_d.sync2 = s_q.sync1;
		flags_nx = {s_q.edge_low[ctu_pkg::FLAG2_BIT], s_q.edge_low[ctu_pkg::FLAG1_BIT]};

		// apb: one wait state, answer in the access cycle's second edge
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		case (s_q.bus_st)
			ctu_pkg::ctu_idle_s: begin
				if (psel & penable) begin
					s_d.bus_st = ctu_pkg::ctu_resp_s;
					s_d.pready = 1'b1;
					s_d.prdata = 32'h0000_0000;
					case (paddr)
						ctu_pkg::OFS_CUR_CTRL: s_d.prdata[7:0] = s_q.cur_ctrl;
						ctu_pkg::OFS_EDGE_LOW: s_d.prdata[7:0] = s_q.edge_low;
						ctu_pkg::OFS_CTRL_HIGH: s_d.prdata[7:0] = s_q.ctrl_high;
						ctu_pkg::OFS_IRQ_STAT: s_d.prdata[7:0] = s_q.irq_stat;
						ctu_pkg::OFS_IRQ_MASK: s_d.prdata[7:0] = s_q.irq_mask;
						default: s_d.pslverr = 1'b1; // unmapped address
					endcase
				end
			end
			ctu_pkg::ctu_resp_s: begin
				s_d.bus_st = ctu_pkg::ctu_idle_s;
			end
			default: s_d.bus_st = ctu_pkg::ctu_idle_s;
		endcase

		// register writes take effect at the pready edge
		if (wr_acc) begin
			case (paddr)
				ctu_pkg::OFS_CUR_CTRL: s_d.cur_ctrl = wb;
				ctu_pkg::OFS_EDGE_LOW: begin
					s_d.edge_low = wb;
					flags_nx = {wb[ctu_pkg::FLAG2_BIT], wb[ctu_pkg::FLAG1_BIT]};
				end
				ctu_pkg::OFS_CTRL_HIGH: s_d.ctrl_high = wb;
				ctu_pkg::OFS_IRQ_MASK: s_d.irq_mask = wb;
				default: ;
			endcase
		end

		// hardware set wins over a same-cycle software clear; the level compare uses
		// current config so a config change matching the live level sets at once
		if (gate_on) begin
			if (ev1) begin
				flags_nx[0] = 1'b1;
			end
			if (ev2 && (!s_q.ctrl_high[ctu_pkg::ORDER_BIT] || s_q.edge_low[ctu_pkg::FLAG1_BIT])) begin
				flags_nx[1] = 1'b1;
			end
		end
		s_d.edge_low[ctu_pkg::FLAG1_BIT] = flags_nx[0];
		s_d.edge_low[ctu_pkg::FLAG2_BIT] = flags_nx[1];

		// current gate: exactly one flag and unit enabled
		cur_nx = (flags_nx[0] ^ flags_nx[1]) & s_d.ctrl_high[ctu_pkg::UNITEN_BIT];
		s_d.cur_prev = cur_nx;
		s_d.ana.current_on = cur_nx;
		s_d.ana.range = s_d.cur_ctrl[ctu_pkg::RANGE_LSB +: 2];
		s_d.ana.trim = s_d.cur_ctrl[ctu_pkg::TRIM_LSB +: 6];
		s_d.ana.unit_en = s_d.ctrl_high[ctu_pkg::UNITEN_BIT];

		// sticky off-event flag: write-one clears, new event wins
		if (wr_acc && paddr == ctu_pkg::OFS_IRQ_STAT) begin
			s_d.irq_stat = s_q.irq_stat & ~wb;
		end
		if (s_q.cur_prev && !cur_nx) begin
			s_d.irq_stat[ctu_pkg::IRQ_OFF_BIT] = 1'b1;
		end
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	// state register; reset gives negative polarity and no sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.bus_st <= ctu_pkg::ctu_idle_s;
			s_q.cur_ctrl <= ctu_pkg::CUR_CTRL_RST;
			s_q.edge_low <= ctu_pkg::EDGE_LOW_RST;
			s_q.ctrl_high <= ctu_pkg::CTRL_HIGH_RST;
			s_q.irq_stat <= ctu_pkg::IRQ_RST;
			s_q.irq_mask <= ctu_pkg::IRQ_RST;
			s_q.sync1 <= 2'h0;
			s_q.sync2 <= 2'h0;
			s_q.cur_prev <= 1'b0;
			s_q.prdata <= 32'h0000_0000;
			s_q.pready <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.irq <= 1'b0;
			s_q.ana <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign ana_out = s_q.ana;
	assign irq = s_q.irq;

	// assertions
	property p_cur_one_flag;
		@(posedge pclk) disable iff (!presetn)
		s_q.ana.current_on == ((s_q.edge_low[0] ^ s_q.edge_low[1]) & s_q.ctrl_high[7]);
	endproperty
	a_cur_one_flag: assert property (p_cur_one_flag) else $error("current gate wrong");

	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		(s_q.edge_low[0] && !(wr_acc && paddr == 8'h04)) |=> s_q.edge_low[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag 1 dropped");

	property p_order;
		@(posedge pclk) disable iff (!presetn)
		(s_q.ctrl_high[2] && !s_q.edge_low[0] && !s_q.edge_low[1] && !wr_acc) |=> !s_q.edge_low[1];
	endproperty
	a_order: assert property (p_order) else $error("channel 2 ahead of channel 1");

	property p_gate;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.ctrl_high[3] && !s_q.edge_low[0] && !wr_acc) |=> !s_q.edge_low[0];
	endproperty
	a_gate: assert property (p_gate) else $error("edge passed while blocked");

	property p_set_on_event;
		@(posedge pclk) disable iff (!presetn)
		(gate_on && ev1) |=> s_q.edge_low[0];
	endproperty
	a_set_on_event: assert property (p_set_on_event) else $error("event missed");

	property p_irq_fall;
		@(posedge pclk) disable iff (!presetn)
		($fell(s_q.ana.current_on)) |-> s_q.irq_stat[0];
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("off event not flagged");

	property p_irq_out;
		@(posedge pclk) disable iff (!presetn)
		(s_q.irq_stat[0] && s_q.irq_mask[0]) |-> irq;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

	property p_sw_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == 8'h04 && wb[1:0] == 2'b01 && s_q.ctrl_high[7] && !gate_on) |=> s_q.ana.current_on;
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software set ignored");

	property p_trim;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == 8'h00) |=> (s_q.ana.trim == $past(wb[7:2]) && s_q.ana.range == $past(wb[1:0]));
	endproperty
	a_trim: assert property (p_trim) else $error("range or trim not applied");

	property p_sync;
		@(posedge pclk) disable iff (!presetn)
		s_q.sync2 == $past(s_q.sync1);
	endproperty
	a_sync: assert property (p_sync) else $error("sync stage skipped");

	// second flag holds like the first
	property p_flag2_sticky;
		@(posedge pclk) disable iff (!presetn)
		(s_q.edge_low[1] && !(wr_acc && paddr == ctu_pkg::OFS_EDGE_LOW)) |=> s_q.edge_low[1];
	endproperty
	a_flag2_sticky: assert property (p_flag2_sticky) else $error("flag 2 dropped");

	// channel 2 event taken once ordering allows it
	property p_set_on_event2;
		@(posedge pclk) disable iff (!presetn)
		(gate_on && ev2 && (!s_q.ctrl_high[2] || s_q.edge_low[0])) |=> s_q.edge_low[1];
	endproperty
	a_set_on_event2: assert property (p_set_on_event2) else $error("channel 2 event missed");

	// blocked edges leave the second flag alone too
	property p_gate2;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.ctrl_high[3] && !s_q.edge_low[1] && !wr_acc) |=> !s_q.edge_low[1];
	endproperty
	a_gate2: assert property (p_gate2) else $error("channel 2 passed while blocked");

	// with the unit off only software moves the flags
	property p_unit_gate;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.ctrl_high[7] && !wr_acc) |=> (s_q.edge_low[1:0] == $past(s_q.edge_low[1:0]));
	endproperty
	a_unit_gate: assert property (p_unit_gate) else $error("flag moved with unit off");

	// no charge flows with the unit switched off
	property p_cur_unit;
		@(posedge pclk) disable iff (!presetn)
		!s_q.ana.unit_en |-> !s_q.ana.current_on;
	endproperty
	a_cur_unit: assert property (p_cur_unit) else $error("current on with unit off");

	// writing both flags equal while edges are blocked switches the source off
	property p_sw_off;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == ctu_pkg::OFS_EDGE_LOW && wb[0] == wb[1] && !gate_on) |=> !s_q.ana.current_on;
	endproperty
	a_sw_off: assert property (p_sw_off) else $error("software clear ignored");

	// interrupt low while no enabled event waits
	property p_irq_low;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.irq_stat[0] || !s_q.irq_mask[0]) |-> !irq;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("spurious interrupt");

	// off-event flag stays until a one is written to it
	property p_irq_sticky;
		@(posedge pclk) disable iff (!presetn)
		(s_q.irq_stat[0] && !(wr_acc && paddr == ctu_pkg::OFS_IRQ_STAT && wb[0])) |=> s_q.irq_stat[0];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("off event flag lost");

	// range and trim only move on a write
	property p_cur_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_acc && paddr == ctu_pkg::OFS_CUR_CTRL) |=> ($stable(s_q.ana.range) && $stable(s_q.ana.trim));
	endproperty
	a_cur_hold: assert property (p_cur_hold) else $error("range or trim drifted");

	// first sync stage takes the raw pins
	property p_sync_in;
		@(posedge pclk) disable iff (!presetn)
		s_q.sync1 == $past({src_in.pin_a, src_in.pin_b});
	endproperty
	a_sync_in: assert property (p_sync_in) else $error("pin not captured");

	// low polarity takes a low raw level as the event
	property p_pol_low;
		@(posedge pclk) disable iff (!presetn)
		(gate_on && !s_q.edge_low[4] && !lvl1) |=> s_q.edge_low[0];
	endproperty
	a_pol_low: assert property (p_pol_low) else $error("low level not taken");

	// pready is a single-cycle answer
	property p_pready_pulse;
		@(posedge pclk) disable iff (!presetn)
		s_q.pready |=> !s_q.pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

	// an access is answered after one wait state
	property p_pready_answer;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !s_q.pready && s_q.bus_st == ctu_pkg::ctu_idle_s) |=> s_q.pready;
	endproperty
	a_pready_answer: assert property (p_pready_answer) else $error("access not answered");

	// error only rides on an answer
	property p_err_with_ready;
		@(posedge pclk) disable iff (!presetn)
		s_q.pslverr |-> s_q.pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error without pready");

endmodule // ctu_edge_ctrl

// file: hdl/ctu_pkg.sv
// package: register map, field positions, reset values and carrier types of the charge-time unit
package ctu_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_CUR_CTRL = 8'h00; // current_source_control
	localparam logic [7:0] OFS_EDGE_LOW = 8'h04; // edge_config_status_low
	localparam logic [7:0] OFS_CTRL_HIGH = 8'h08; // unit_control_high
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c; // sticky event flags, write one to clear
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10; // interrupt enables, same layout

	// current_source_control fields
	localparam int RANGE_LSB = 0;
	localparam int TRIM_LSB = 2;

	// edge_config_status_low fields
	localparam int FLAG1_BIT = 0;
	localparam int FLAG2_BIT = 1;
	localparam int SEL1_LSB = 2;
	localparam int POL1_BIT = 4;
	localparam int SEL2_LSB = 5;
	localparam int POL2_BIT = 7;

	// unit_control_high fields
	localparam int ORDER_BIT = 2;
	localparam int EDGE_INPUTS_ENABLE_BIT = 3;
	localparam int UNITEN_BIT = 7;

	// interrupt status/mask field: current source switched off
	localparam int IRQ_OFF_BIT = 0;

	// reset values: polarity bits low (negative), sequencing off, unit off
	localparam logic [7:0] CUR_CTRL_RST = 8'h00;
	localparam logic [7:0] EDGE_LOW_RST = 8'h00;
	localparam logic [7:0] CTRL_HIGH_RST = 8'h00;
	localparam logic [7:0] IRQ_RST = 8'h00;

	// edge source select codes
	localparam logic [1:0] SRC_PIN_A = 2'h0;
	localparam logic [1:0] SRC_PIN_B = 2'h1;
	localparam logic [1:0] SRC_TIMER = 2'h2;
	localparam logic [1:0] SRC_CMP = 2'h3;

	// apb read-out stage
	typedef enum logic [1:0] {
		ctu_idle_s = 2'b01,
		ctu_resp_s = 2'b10
	} ctu_bus_st_t;

	// edge source inputs, shared by both channels
	typedef struct packed {
		logic pin_a;
		logic pin_b;
		logic timer;
		logic cmp;
	} ctu_src_t;

	// analog-side outputs
	typedef struct packed {
		logic current_on;
		logic [1:0] range;
		logic [5:0] trim;
		logic unit_en;
	} ctu_ana_t;

	// whole state of the block
	typedef struct packed {
		ctu_bus_st_t bus_st;
		logic [7:0] cur_ctrl;
		logic [7:0] edge_low;
		logic [7:0] ctrl_high;
		logic [7:0] irq_stat;
		logic [7:0] irq_mask;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic cur_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		ctu_ana_t ana;
	} ctu_state_t;

endpackage : ctu_pkg

// file: bench/ctu_src_model.sv
// partner model: edge trigger sources and analog load of the charge-time unit
`timescale 1ns/1ps
module ctu_src_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// source levels asked for by the bench {pin_a,pin_b,timer,cmp}
	input wire logic [3:0] want,
	// analog side of the design
	input wire ctu_pkg::ctu_ana_t ana,
	// edge sources to the design
	output ctu_pkg::ctu_src_t src,
	// cycles for which charge flowed
	output int on_cycles
);
	// sources move just after an edge, as on-chip timer outputs do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src <= '0;
			on_cycles <= 0;
		end else begin
			src <= want;
			// the load only charges while the source is switched on
			if (ana.current_on) begin
				on_cycles <= on_cycles + 1;
			end
		end
	end
endmodule // ctu_src_model

// file: bench/tb_charge_time_edge_control.sv
// testbench: register, edge channel and interrupt checks of the charge-time unit
`timescale 1ns/1ps
module tb_charge_time_edge_control;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] want; // requested source levels
	ctu_pkg::ctu_src_t src;
	ctu_pkg::ctu_ana_t ana;
	int bad_count, compares, fl, ist, on_cycles, s, m, v;
	int fseq[$] = '{1, 3, 2, 0}; // flag write order for the model
	ctu_edge_ctrl ctu_edge_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_in(src), .ana_out(ana), .irq(irq));
	ctu_src_model ctu_src_model_i (.pclk(pclk), .presetn(presetn), .want(want), .ana(ana), .src(src),
		.on_cycles(on_cycles));
	// 100 mhz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; only the watchdog ends a hung wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	// model: current only with exactly one flag
	task automatic cc();
		chk({31'h0, ana.current_on}, {31'h0, fl == 1 || fl == 2});
	endtask
	// software flag write, tracking the off-interrupt in the model
	task automatic fw(input int f);
		if ((fl == 1 || fl == 2) && !(f == 1 || f == 2)) ist = 1;
		fl = f;
		wr(ctu_pkg::OFS_EDGE_LOW, 8'(f));
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		#300000;
		bad_count++;
		final_report();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, want, presetn} = '0;
		{bad_count, compares, fl, ist} = '0;
		void'($urandom(32'h5de5b25e));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, then an unmapped read
		for (int a = 0; a < 5; a++) rdc(8'(a * 4), 32'h0);
		rdc(8'h20, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test reset done");
		// range and trim, mid-scale trims 1f and 20 first
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 'h7c : (i == 1) ? 'h80 : $urandom;
			wr(ctu_pkg::OFS_CUR_CTRL, 8'(v));
			rdc(ctu_pkg::OFS_CUR_CTRL, {24'h0, 8'(v)});
			wt(2);
			chk({24'h0, ana.trim, ana.range}, {24'h0, 8'(v)});
			chk({31'h0, ana.unit_en}, 32'h0);
		end
		$display("test current settings done");
		// software flags, with and without interrupt mask
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h80);
		for (m = 1; m >= 0; m--) begin
			wr(ctu_pkg::OFS_IRQ_MASK, 8'(m));
			foreach (fseq[k]) begin
				fw(fseq[k]);
				wt(3);
				cc();
				chk({31'h0, irq}, {31'h0, ist == 1 && m == 1});
			end
			rdc(ctu_pkg::OFS_IRQ_STAT, 32'(ist));
			wr(ctu_pkg::OFS_IRQ_STAT, 8'h01);
			ist = 0;
			wt(3);
			chk({31'h0, irq}, 32'h0);
		end
		$display("test software flags done");
		// each source code on channel 1, channel 2 parked on another source
		for (s = 0; s < 4; s++) begin
			wr(ctu_pkg::OFS_EDGE_LOW, {1'b1, 2'((s + 1) % 4), 1'b1, 2'(s), 2'b00});
			wr(ctu_pkg::OFS_CTRL_HIGH, 8'h88);
			want <= 4'b1000 >> s;
			fl = 1;
			wt(6);
			rdc(ctu_pkg::OFS_EDGE_LOW, {24'h0, 1'b1, 2'((s + 1) % 4), 1'b1, 2'(s), 2'b01});
			cc();
			chk({31'h0, ana.unit_en}, 32'h1);
			want <= 4'h0;
			wt(6);
			cc();
			rdc(ctu_pkg::OFS_EDGE_LOW, {24'h0, 1'b1, 2'((s + 1) % 4), 1'b1, 2'(s), 2'b01});
			wr(ctu_pkg::OFS_CTRL_HIGH, 8'h80);
			fw(0);
		end
		// polarity turned to match the present low level
		wr(ctu_pkg::OFS_EDGE_LOW, 8'hb0);
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h88);
		wr(ctu_pkg::OFS_EDGE_LOW, 8'ha0);
		wt(4);
		rdc(ctu_pkg::OFS_EDGE_LOW, 32'ha1);
		// channel 2 on a low level, channel 1 idle, no ordering
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h80);
		wr(ctu_pkg::OFS_EDGE_LOW, 8'h30);
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h88);
		wt(4);
		rdc(ctu_pkg::OFS_EDGE_LOW, 32'h32);
		fl = 2;
		cc();
		$display("test edge channels done");
		// ordering: channel 2 waits for channel 1
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h80);
		wr(ctu_pkg::OFS_EDGE_LOW, 8'hb0);
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h8c);
		want <= 4'b0100;
		wt(6);
		rdc(ctu_pkg::OFS_EDGE_LOW, 32'hb0);
		want <= 4'b1100;
		wt(6);
		rdc(ctu_pkg::OFS_EDGE_LOW, 32'hb3);
		fl = 3;
		cc();
		// edge inputs blocked while edge enable is clear
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h80);
		wr(ctu_pkg::OFS_EDGE_LOW, 8'hb0);
		wt(6);
		rdc(ctu_pkg::OFS_EDGE_LOW, 32'hb0);
		wr(ctu_pkg::OFS_CTRL_HIGH, 8'h08);
		wr(ctu_pkg::OFS_EDGE_LOW, 8'h01);
		wt(3);
		chk({31'h0, ana.current_on}, 32'h0);
		chk({31'h0, ana.unit_en}, 32'h0);
		@(posedge pclk);
		want <= 4'h0;
		chk({31'h0, on_cycles != 0}, 32'h1);
		$display("test ordering and enables done");
		final_report();
	end
endmodule // tb_charge_time_edge_control
